// file: bench/rca_ctrl_tb.sv
// Purpose: register-level bench of the clock control, trim and alarm configuration block
// Assumes: apb slave answers in the second access cycle; neighbour values held constant
// Notes: short second (34 ticks) keeps the ripple and half-second windows reachable
`timescale 1ns/1ps

module rca_ctrl_tb;
    import rca_pkg::*;

    logic sys_clk;
    logic rst_n;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rca_time_t time_now;
    rca_time_t alarm_val;
    logic [15:0] win_rdata;
    rca_win_t win_acc;
    logic sec_tick;
    logic run;
    logic clk_pin_out;
    logic clk_pin_oe_n;
    logic pmp_ttl_sel;
    logic [31:0] rd_data;
    logic rd_err;
    logic [1:0] last_ptr;
    rca_win_t last_acc;
    int err_count = 0;
    int cmp_count = 0;
    int strb_n = 0;

    rca_ctrl #(.PULSES_PER_SEC(34)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .time_now(time_now), .alarm_val(alarm_val),
        .win_rdata(win_rdata), .win_acc(win_acc), .sec_tick(sec_tick), .run(run),
        .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n), .pmp_ttl_sel(pmp_ttl_sel));

    always #4 sys_clk = ~sys_clk;

    // window strobes seen by the neighbour
    always @(posedge sys_clk) begin
        if (win_acc.strobe === 1'b1) begin
            strb_n++;
            last_ptr = win_acc.ptr;
            last_acc = win_acc;
        end
    end

    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d, input logic [3:0] s);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            end_sim();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
        apb(a, 1'b1, d, s);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
        apb(a, 1'b0, 16'h0000, 4'hf);
        chk(rd_data & {16'h0000, m}, {16'h0000, e});
    endtask

    task automatic pins(input logic oe_n, input logic o);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, clk_pin_oe_n, clk_pin_out}, {30'h0, oe_n, o});
    endtask

    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        end_sim();
    end

    initial begin
        int n;
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        time_now = 56'h0;
        alarm_val = 56'h0;
        win_rdata = 16'h5a3c;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(RCA_ADDR_CFGCAL, 16'hffff, 16'h0000);
        rdc(RCA_ADDR_PAD, 16'hffff, 16'h0000);
        rdc(RCA_ADDR_ALCFG, 16'hffff, 16'h0000);
        rdc(12'h014, 16'hffff, 16'h0000);
        chk({31'h0, rd_err}, 32'h1);
        wr(RCA_ADDR_CFGCAL, 16'h8000, 4'h3);
        rdc(RCA_ADDR_CFGCAL, 16'he7ff, 16'h0000);
        chk({31'h0, run}, 32'h0);
        wr(RCA_ADDR_CFGCAL, 16'h2000, 4'h3);
        wr(RCA_ADDR_CFGCAL, 16'ha07f, 4'h3);
        rdc(RCA_ADDR_CFGCAL, 16'he7ff, 16'ha07f);
        chk({31'h0, run}, 32'h1);
        wr(RCA_ADDR_CFGCAL, 16'ha080, 4'h3);
        rdc(RCA_ADDR_CFGCAL, 16'he7ff, 16'ha080);
        wr(RCA_ADDR_PAD, 16'h0003, 4'h3);
        rdc(RCA_ADDR_PAD, 16'hffff, 16'h0003);
        chk({31'h0, pmp_ttl_sel}, 32'h1);
        wr(RCA_ADDR_CFGCAL, 16'ha400, 4'h3);
        pins(1'b0, 1'b1);
        wr(RCA_ADDR_PAD, 16'h0001, 4'h3);
        pins(1'b0, 1'b0);
        wr(RCA_ADDR_CFGCAL, 16'ha300, 4'h3);
        pins(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rdc(RCA_ADDR_TWIN, 16'hffff, 16'h5a3c);
            repeat (2) @(posedge sys_clk);
            chk({30'h0, last_ptr}, (i < 3) ? 32'(3 - i) : 32'h0);
            rdc(RCA_ADDR_CFGCAL, 16'h0300, (i < 2) ? 16'((2 - i) << 8) : 16'h0000);
        end
        wr(RCA_ADDR_ALCFG, 16'h0200, 4'h3);
        wr(RCA_ADDR_AWIN, 16'h0011, 4'h1);
        rdc(RCA_ADDR_ALCFG, 16'hffff, 16'h0200);
        wr(RCA_ADDR_AWIN, 16'h1100, 4'h2);
        rdc(RCA_ADDR_ALCFG, 16'hffff, 16'h0100);
        rdc(RCA_ADDR_AWIN, 16'hffff, 16'h5a3c);
        rdc(RCA_ADDR_ALCFG, 16'hffff, 16'h0000);
        chk(32'(last_acc), {9'h0, 1'b1, 1'b0, 1'b1, 2'h1, 2'h3, 16'h0000});
        for (int k = 0; k < 10; k++) begin
            wr(RCA_ADDR_ALCFG, 16'h4005 | 16'(k << 10), 4'h3);
            rdc(RCA_ADDR_ALCFG, 16'hffff, 16'h4005 | 16'(k << 10));
        end
        wr(RCA_ADDR_CFGCAL, 16'h8000, 4'h3);
        wr(RCA_ADDR_CFGCAL, 16'h0000, 4'h3);
        rdc(RCA_ADDR_CFGCAL, 16'he7ff, 16'h8000);
        n = strb_n;
        wr(RCA_ADDR_TWIN, 16'h1234, 4'h3);
        repeat (3) @(posedge sys_clk);
        chk(32'(strb_n), 32'(n));
        wr(RCA_ADDR_CFGCAL, 16'ha000, 4'h3);
        // half-second alarm with chime: its one event wraps the repeat count
        wr(RCA_ADDR_ALCFG, 16'hc000, 4'h3);
        // zero the prescaler, then let 18 of 34 ticks pass
        wr(RCA_ADDR_TWIN, 16'h0000, 4'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'(strb_n), 32'(n + 1));
        chk(32'(last_acc), {9'h0, 1'b1, 1'b1, 1'b0, 2'h0, 2'h1, 16'h0000});
        repeat (70000) @(posedge sys_clk);
        rdc(RCA_ADDR_CFGCAL, 16'h1800, 16'h1800);
        for (int j = 0; j < 2; j++) begin
            rdc(RCA_ADDR_ALCFG, 16'hffff, 16'hc0ff);
        end
        // disabled: prescaler frozen past the half, ripple flag low
        wr(RCA_ADDR_CFGCAL, 16'h2000, 4'h3);
        repeat (4000) @(posedge sys_clk);
        rdc(RCA_ADDR_CFGCAL, 16'h1800, 16'h0800);
        chk({31'h0, run}, 32'h0);
        wr(RCA_ADDR_CFGCAL, 16'ha000, 4'h3);
        wr(RCA_ADDR_TWIN, 16'h0000, 4'h1);
        rdc(RCA_ADDR_CFGCAL, 16'h1800, 16'h0000);
        end_sim();
    end
endmodule

// file: hw/rca_ctrl.sv
// Purpose: control, drift trim, window pointers and alarm configuration of the clock unit
// Assumes: rst_n is the power-on reset; time and alarm values come from a neighbour
// Notes: apb slave answers with pready in the second access cycle
`timescale 1ns/1ps

module rca_ctrl #(
    parameter int PULSES_PER_SEC = rca_pkg::RCA_PULSES_PER_SEC
) (
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // value registers in the neighbouring block
    input wire rca_pkg::rca_time_t time_now,
    input wire rca_pkg::rca_time_t alarm_val,
    input wire logic [15:0] win_rdata,
    output rca_pkg::rca_win_t win_acc,
    output logic sec_tick,
    output logic run,
    // pads
    output logic clk_pin_out,
    output logic clk_pin_oe_n,
    output logic pmp_ttl_sel
);
    import rca_pkg::*;

    localparam logic [11:0] OSC_DIV_M1 = 12'(RCA_OSC_DIV - 1);
    localparam logic signed [17:0] SEC_END = 18'(PULSES_PER_SEC - 1);
    localparam logic signed [17:0] HALF_AT = 18'(PULSES_PER_SEC / 2);
    localparam logic signed [17:0] RIPPLE_AT = 18'(PULSES_PER_SEC - RCA_RIPPLE_PULSES);
    localparam logic signed [17:0] CAL_STEP = 18'(RCA_CAL_STEP);

    logic en_r, wren_r, oe_r, ripple_r;
    logic [1:0] tptr_r, aptr_r;
    logic [7:0] cal_r;
    logic secsel_r, buf_r;
    logic al_en_r, chime_r;
    logic [3:0] ival_r;
    logic [7:0] rpt_r;
    logic [11:0] osc_div_r;
    logic osc_tick_r;
    logic signed [17:0] psc_r;
    logic [5:0] sec_cnt_r;
    logic half_r, half_tick_r, eval_r, eval_half_r;
    logic alarm_pulse_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    rca_win_t win_acc_r;
    logic sec_tick_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    logic acc, wr, hi_wr, lo_wr;
    logic sel_cfg, sel_pad, sel_al, sel_tw, sel_aw, mapped;
    logic win_ok, win_step, sec_end, minutes_seconds_value_lo_wr, alarm_hit;

    assign acc = psel && penable && pready_r;
    assign wr = acc && pwrite;
    assign hi_wr = wr && pstrb[1];
    assign lo_wr = wr && pstrb[0];
    assign sel_cfg = paddr == RCA_ADDR_CFGCAL;
    assign sel_pad = paddr == RCA_ADDR_PAD;
    assign sel_al = paddr == RCA_ADDR_ALCFG;
    assign sel_tw = paddr == RCA_ADDR_TWIN;
    assign sel_aw = paddr == RCA_ADDR_AWIN;
    assign mapped = sel_cfg || sel_pad || sel_al || sel_tw || sel_aw;
    // window writes pass only while unlocked; reads always pass
    assign win_ok = !pwrite || wren_r;
    // any read steps the pointer; a write only if it hits the high byte
    assign win_step = acc && win_ok && (!pwrite || pstrb[1]);
    assign minutes_seconds_value_lo_wr = lo_wr && sel_tw && wren_r && tptr_r == 2'h0;
    assign sec_end = osc_tick_r && en_r && psc_r >= SEC_END;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r <= 32'h0000_0000;
            if (sel_cfg) begin
                prdata_r[15:0] <= {en_r, 1'b0, wren_r, ripple_r, half_r, oe_r, tptr_r, cal_r};
            end
            if (sel_pad) begin
                prdata_r[1:0] <= {secsel_r, buf_r};
            end
            if (sel_al) begin
                prdata_r[15:0] <= {al_en_r, chime_r, ival_r, aptr_r, rpt_r};
            end
            if (sel_tw || sel_aw) begin
                prdata_r[15:0] <= win_rdata;
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock_config_calibration, power-on reset only

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= RCA_CFG_RST[RCA_CFG_EN_BIT];
            wren_r <= RCA_CFG_RST[RCA_CFG_WREN_BIT];
            oe_r <= RCA_CFG_RST[RCA_CFG_OE_BIT];
            cal_r <= RCA_CFG_RST[7:0];
        end else if (sel_cfg) begin
            if (hi_wr) begin
                wren_r <= pwdata[RCA_CFG_WREN_BIT];
                oe_r <= pwdata[RCA_CFG_OE_BIT];
                if (wren_r) begin
                    en_r <= pwdata[RCA_CFG_EN_BIT];
                end
            end
            if (lo_wr) begin
                cal_r <= pwdata[7:0];
            end
        end
    end

    // time window pointer: software write or a step toward zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tptr_r <= RCA_CFG_RST[RCA_PTR_LSB+:2];
        end else if (hi_wr && sel_cfg) begin
            tptr_r <= pwdata[RCA_PTR_LSB+:2];
        end else if (win_step && sel_tw && tptr_r != 2'h0) begin
            tptr_r <= tptr_r - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad_configuration

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secsel_r <= RCA_PAD_RST[RCA_PAD_SECSEL_BIT];
            buf_r <= RCA_PAD_RST[RCA_PAD_BUF_BIT];
        end else if (lo_wr && sel_pad) begin
            secsel_r <= pwdata[RCA_PAD_SECSEL_BIT];
            buf_r <= pwdata[RCA_PAD_BUF_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // window access strobe to the value registers

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            win_acc_r <= '0;
        end else begin
            win_acc_r.strobe <= acc && win_ok && (sel_tw || sel_aw);
            win_acc_r.write <= pwrite;
            win_acc_r.alarm <= sel_aw;
            win_acc_r.ptr <= sel_aw ? aptr_r : tptr_r;
            win_acc_r.bytes <= pwrite ? pstrb[1:0] : 2'h3;
            win_acc_r.wdata <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timebase: free-running oscillator divider, prescaler with trim, seconds in the minute

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_div_r <= 12'h000;
            osc_tick_r <= 1'b0;
        end else begin
            osc_tick_r <= osc_div_r == OSC_DIV_M1;
            osc_div_r <= (osc_div_r == OSC_DIV_M1) ? 12'h000 : osc_div_r + 12'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            psc_r <= 18'sh00000;
        end else if (minutes_seconds_value_lo_wr) begin
            psc_r <= 18'sh00000;
        end else if (sec_end) begin
            if (sec_cnt_r == RCA_LAST_SEC) begin
                psc_r <= CAL_STEP * 18'(signed'(cal_r));
            end else begin
                psc_r <= 18'sh00000;
            end
        end else if (osc_tick_r && en_r) begin
            psc_r <= psc_r + 18'sh00001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_r <= 6'h00;
        end else if (sec_end) begin
            sec_cnt_r <= (sec_cnt_r == RCA_LAST_SEC) ? 6'h00 : sec_cnt_r + 6'h01;
        end
    end

    // status and tick pulses
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_r <= 1'b0;
            half_tick_r <= 1'b0;
            ripple_r <= 1'b0;
            sec_tick_r <= 1'b0;
            eval_r <= 1'b0;
            eval_half_r <= 1'b0;
        end else begin
            half_r <= !minutes_seconds_value_lo_wr && psc_r >= HALF_AT;
            half_tick_r <= osc_tick_r && en_r && psc_r == HALF_AT - 18'sh00001;
            ripple_r <= en_r && psc_r >= RIPPLE_AT;
            sec_tick_r <= sec_end;
            // compare one cycle after the neighbour takes the tick
            eval_r <= sec_tick_r;
            eval_half_r <= half_tick_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm match

    logic m_s1, m_sec, m_m1, m_min, m_hr, m_wd, m_day, m_mon, leap, match, eval;

    assign m_s1 = time_now.seconds[3:0] == alarm_val.seconds[3:0];
    assign m_sec = time_now.seconds == alarm_val.seconds;
    assign m_m1 = time_now.minutes[3:0] == alarm_val.minutes[3:0];
    assign m_min = time_now.minutes == alarm_val.minutes;
    assign m_hr = time_now.hours == alarm_val.hours;
    assign m_wd = time_now.weekday == alarm_val.weekday;
    assign m_day = time_now.day == alarm_val.day;
    assign m_mon = time_now.month == alarm_val.month;
    // bcd year divisible by four
    assign leap = time_now.year[4] ? (time_now.year[3:0] == 4'h2 || time_now.year[3:0] == 4'h6)
                                   : (time_now.year[1:0] == 2'h0 && time_now.year[3:0] != 4'hc);
    assign eval = (ival_r == RCA_IV_HALF) ? (eval_half_r || eval_r) : eval_r;

    always_comb begin
        match = 1'b1;
        if (ival_r > RCA_IV_YEAR) begin
            match = 1'b0;
        end
        if (ival_r >= RCA_IV_10SEC && !m_s1) begin
            match = 1'b0;
        end
        if (ival_r >= RCA_IV_MIN && !m_sec) begin
            match = 1'b0;
        end
        if (ival_r >= RCA_IV_10MIN && !m_m1) begin
            match = 1'b0;
        end
        if (ival_r >= RCA_IV_HOUR && !m_min) begin
            match = 1'b0;
        end
        if (ival_r >= RCA_IV_DAY && !m_hr) begin
            match = 1'b0;
        end
        if (ival_r == RCA_IV_WEEK && !m_wd) begin
            match = 1'b0;
        end
        if (ival_r >= RCA_IV_MONTH && !m_day) begin
            match = 1'b0;
        end
        if (ival_r == RCA_IV_YEAR && !m_mon) begin
            match = 1'b0;
        end
        if (ival_r == RCA_IV_YEAR && alarm_val.month == RCA_FEB_BCD && alarm_val.day == RCA_DAY29_BCD
            && !leap) begin
            match = 1'b0;
        end
    end

    assign alarm_hit = al_en_r && en_r && eval && match;

    ////////////////////////////////////////////////////////////////////////////
    // alarm_configuration; a software write wins over the event update

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            al_en_r <= RCA_ALCFG_RST[RCA_AL_EN_BIT];
            chime_r <= RCA_ALCFG_RST[RCA_AL_CHIME_BIT];
            ival_r <= RCA_ALCFG_RST[RCA_AL_MASK_LSB+:4];
            rpt_r <= RCA_ALCFG_RST[7:0];
        end else begin
            if (alarm_hit) begin
                if (rpt_r == 8'h00 && !chime_r) begin
                    al_en_r <= 1'b0;
                end
                if (rpt_r != 8'h00 || chime_r) begin
                    rpt_r <= rpt_r - 8'h01;
                end
            end
            if (hi_wr && sel_al) begin
                al_en_r <= pwdata[RCA_AL_EN_BIT];
                chime_r <= pwdata[RCA_AL_CHIME_BIT];
                ival_r <= pwdata[RCA_AL_MASK_LSB+:4];
            end
            if (lo_wr && sel_al) begin
                rpt_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aptr_r <= RCA_ALCFG_RST[RCA_PTR_LSB+:2];
        end else if (hi_wr && sel_al) begin
            aptr_r <= pwdata[RCA_PTR_LSB+:2];
        end else if (win_step && sel_aw && aptr_r != 2'h0) begin
            aptr_r <= aptr_r - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pin

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_pulse_r <= 1'b0;
            clk_pin_out <= 1'b0;
            clk_pin_oe_n <= 1'b1;
        end else begin
            alarm_pulse_r <= alarm_hit;
            clk_pin_out <= secsel_r ? !half_r : alarm_pulse_r;
            clk_pin_oe_n <= !oe_r;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign win_acc = win_acc_r;
    assign sec_tick = sec_tick_r;
    assign run = en_r;
    assign pmp_ttl_sel = buf_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_enable_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wren_r |=> $stable(en_r))
        else $error("enable changed while locked");
    a_window_write_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        win_acc_r.strobe && win_acc_r.write |-> $past(wren_r))
        else $error("window write passed while locked");
    a_count_halted: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !en_r && !minutes_seconds_value_lo_wr |=> $stable(psc_r))
        else $error("prescaler ran while disabled");
    a_half_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
        minutes_seconds_value_lo_wr |=> !half_r ##1 !half_r)
        else $error("half flag not cleared");
    a_pointer_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        win_step && sel_tw && tptr_r != 2'h0 && !(hi_wr && sel_cfg) |=> tptr_r == $past(tptr_r) - 2'h1)
        else $error("time pointer did not step");
    a_pin_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !oe_r |=> clk_pin_oe_n)
        else $error("pin driven with output disabled");
    a_alarm_selfclear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        alarm_hit && rpt_r == 8'h00 && !chime_r && !(hi_wr && sel_al) |=> !al_en_r)
        else $error("alarm enable not cleared");
    a_chime_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        alarm_hit && rpt_r == 8'h00 && chime_r && !(lo_wr && sel_al) |=> rpt_r == 8'hff)
        else $error("repeat counter did not wrap");
    a_alarm_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        alarm_hit |=> alarm_pulse_r ##1 (clk_pin_out || secsel_r || $past(secsel_r)))
        else $error("alarm pulse missing on pin");
    a_trim_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sec_end && sec_cnt_r == RCA_LAST_SEC && !minutes_seconds_value_lo_wr |=> psc_r == CAL_STEP * 18'(signed'($past(cal_r))))
        else $error("trim not applied at minute");
    a_ripple_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sec_tick_r |-> $past(ripple_r))
        else $error("ripple flag low before rollover");

endmodule

// file: hw/rca_pkg.sv
// Purpose: constants and carrier types of the clock control, trim and alarm block
// Assumes: 32-bit apb, 16-bit registers in the low half of each word
// Notes: the value registers behind the two windows live in a neighbouring block
package rca_pkg;

    // register byte addresses
    localparam logic [11:0] RCA_ADDR_CFGCAL = 12'h000;
    localparam logic [11:0] RCA_ADDR_PAD = 12'h004;
    localparam logic [11:0] RCA_ADDR_ALCFG = 12'h008;
    localparam logic [11:0] RCA_ADDR_TWIN = 12'h00c;
    localparam logic [11:0] RCA_ADDR_AWIN = 12'h010;

    // clock_config_calibration fields
    localparam int RCA_CFG_EN_BIT = 15;
    localparam int RCA_CFG_WREN_BIT = 13;
    localparam int RCA_CFG_SYNC_BIT = 12;
    localparam int RCA_CFG_HALF_BIT = 11;
    localparam int RCA_CFG_OE_BIT = 10;
    localparam int RCA_PTR_LSB = 8;
    // pad_configuration fields
    localparam int RCA_PAD_SECSEL_BIT = 1;
    localparam int RCA_PAD_BUF_BIT = 0;
    // alarm_configuration fields
    localparam int RCA_AL_EN_BIT = 15;
    localparam int RCA_AL_CHIME_BIT = 14;
    localparam int RCA_AL_MASK_LSB = 10;

    // reset values
    localparam logic [15:0] RCA_CFG_RST = 16'h0000;
    localparam logic [1:0] RCA_PAD_RST = 2'h0;
    localparam logic [15:0] RCA_ALCFG_RST = 16'h0000;

    // alarm interval codes
    localparam logic [3:0] RCA_IV_HALF = 4'h0;
    localparam logic [3:0] RCA_IV_10SEC = 4'h2;
    localparam logic [3:0] RCA_IV_MIN = 4'h3;
    localparam logic [3:0] RCA_IV_10MIN = 4'h4;
    localparam logic [3:0] RCA_IV_HOUR = 4'h5;
    localparam logic [3:0] RCA_IV_DAY = 4'h6;
    localparam logic [3:0] RCA_IV_WEEK = 4'h7;
    localparam logic [3:0] RCA_IV_MONTH = 4'h8;
    localparam logic [3:0] RCA_IV_YEAR = 4'h9;
    localparam logic [7:0] RCA_FEB_BCD = 8'h02;
    localparam logic [7:0] RCA_DAY29_BCD = 8'h29;

    // timing
    localparam int RCA_CLK_HZ = 125_000_000;
    localparam int RCA_OSC_HZ = 32768;
    localparam int RCA_OSC_DIV = RCA_CLK_HZ / RCA_OSC_HZ;
    localparam int RCA_PULSES_PER_SEC = 32768;
    localparam int RCA_CAL_STEP = 4;
    localparam int RCA_RIPPLE_PULSES = 32;
    localparam logic [5:0] RCA_LAST_SEC = 6'h3b;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rca_time_t;

    typedef struct packed {
        logic strobe;
        logic write;
        logic alarm;
        logic [1:0] ptr;
        logic [1:0] bytes;
        logic [15:0] wdata;
    } rca_win_t;

endpackage
